// [sfc_pkg.sv]
// shared constants and types of the sdlc frame channel
package sfc_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CMD = 3'h1;
    localparam logic [2:0] ADDR_TXDATA = 3'h2;
    localparam logic [2:0] ADDR_RXDATA = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    // control register fields
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_IDLE_FLAGS = 1;
    localparam int CTRL_ABORT_UND = 2;
    localparam int CTRL_RX_EN = 3;
    localparam int CTRL_MODE_LO = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // command register bits, each a one-shot action
    localparam int CMD_TX_INT_RESET = 0;
    localparam int CMD_EOM_RESET = 1;
    localparam int CMD_ERROR_RESET = 2;
    localparam int CMD_ARM_FIRST = 3;
    localparam int CMD_HUNT = 4;
    localparam int CMD_EXT_RESET = 5;

    // status register fields
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_HUNT = 2;
    localparam int ST_EOM_LATCH = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_EOF = 5;
    localparam int ST_CRC_ERR = 6;
    localparam int ST_LOCKED = 7;

    // receive interrupt modes of the interrupt_mode_control field
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_FIRST = 2'h1;
    localparam logic [1:0] MODE_EVERY = 2'h2;
    localparam logic [1:0] MODE_SPECIAL = 2'h3;

    // line patterns and crc
    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;
    localparam logic [4:0] CHAR_BITS = 5'h08;
    localparam logic [4:0] CRC_BITS = 5'h10;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [2:0] FLAG_ONES = 3'h6;

    // timing in bit-times
    localparam int TX_START_BITS = 6;
    localparam int RX_AVAIL_BITS = 11;
    localparam int RX_WINDOW_BITS = 7;
    localparam logic [2:0] RX_WINDOW_FULL = 3'(RX_WINDOW_BITS);
    localparam logic [2:0] RX_HOLD_BITS = 3'(RX_AVAIL_BITS - RX_WINDOW_BITS);

    localparam logic TX_EOM_LATCH_RESET = 1'b1;

    typedef enum logic [4:0] {
        SFC_TX_MARK = 5'b00001,
        SFC_TX_FLAG = 5'b00010,
        SFC_TX_DATA = 5'b00100,
        SFC_TX_CRC = 5'b01000,
        SFC_TX_ABORT = 5'b10000
    } sfc_tx_kind_e;
endpackage

// [sfc_crc_step.sv]
// one bit step of the reflected frame check sequence
`timescale 1ns/1ps
module sfc_crc_step #(
    parameter logic [15:0] POLY = sfc_pkg::CRC_POLY
) (
    input wire logic [15:0] crc_i,
    input wire logic bit_i,
    output logic [15:0] crc_o
);
    logic feedback;
    assign feedback = crc_i[0] ^ bit_i;
    assign crc_o = {1'b0, crc_i[15:1]} ^ (feedback ? POLY : 16'h0000);
endmodule

// [sfc_frame_channel.sv]
// sdlc frame channel: transmit framer, receive deframer and register port
`timescale 1ns/1ps
// Functional notes
// - transmit bits change on transmit clock fall
// - idle as marking line or repeated flags
// - buffer-to-shifter transfer raises buffer-empty interrupt
// - first frame bit leaves six bit-times later
// - buffer-empty interrupts eight to ten bit-times apart
// - both empty signals underrun as external interrupt
// - underrun sends flags if latched, else crc or abort per control
// - frame check is sixteen bits before stuffing
// - one more buffer-empty interrupt after crc
// - back-to-back frames share exactly one flag
// - marking idle sends one closing flag only
// - receive bits sampled on receive clock rise
// - receive status changes on receive clock edges
// - four receive interrupt modes offered
// - first-character mode interrupts on one character until rearmed by command
// - special-only mode gives no character interrupts
// - two-bit mode field selects the mode
// - character available eleven bit-times after last bit
// - end of frame locks buffer until error reset
module sfc_frame_channel (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic transmit_bit_clock_i,
    output logic tx_data_o,
    input wire logic receive_bit_clock_i,
    input wire logic rx_data_i,
    output logic tx_int_o,
    output logic ext_int_o,
    output logic rx_int_o,
    output logic rx_dma_req_o
);
    typedef struct packed {
        logic [2:0] txc_s;
        logic txc_lvl;
        logic [2:0] rxc_s;
        logic rxc_lvl;
        logic [2:0] rxd_s;
        logic [7:0] ctrl;
        sfc_pkg::sfc_tx_kind_e tx_kind;
        logic [7:0] tx_sh;
        logic [4:0] tx_cnt;
        logic [2:0] tx_ones;
        logic [15:0] tx_crc;
        logic [5:0] tx_pipe;
        logic [7:0] tx_buf;
        logic tx_full;
        logic eom_latch;
        logic tx_int;
        logic ext_int;
        logic rx_hunt;
        logic [2:0] rx_ones;
        logic [6:0] rx_dly;
        logic [2:0] rx_dv;
        logic [7:0] rx_asm;
        logic [2:0] rx_bits;
        logic [15:0] rx_crc;
        logic rx_cd_act;
        logic [2:0] rx_cd;
        logic [7:0] rx_hold;
        logic rx_flag_pend;
        logic rx_bad_pend;
        logic [7:0] rx_buf;
        logic rx_full;
        logic rx_ovr;
        logic rx_eof;
        logic rx_crc_err;
        logic rx_locked;
        logic rx_armed;
        logic rx_first;
        logic rx_int;
        logic rx_dma;
        logic [7:0] rd_data;
    } sfc_state_s;

    sfc_state_s cur;
    sfc_state_s next;
    logic [15:0] tx_crc_next;
    logic [15:0] rx_crc_next;

    sfc_crc_step #(.POLY(sfc_pkg::CRC_POLY)) u_tx_crc (
        .crc_i(cur.tx_crc),
        .bit_i(cur.tx_sh[0]),
        .crc_o(tx_crc_next)
    );

    sfc_crc_step #(.POLY(sfc_pkg::CRC_POLY)) u_rx_crc (
        .crc_i(cur.rx_crc),
        .bit_i(cur.rx_dly[6]),
        .crc_o(rx_crc_next)
    );

    always_comb begin
        logic tx_fall;
        logic rx_rise;
        logic tx_bit;
        logic stuff;
        logic rx_d;
        logic [1:0] mode;
        logic special;
        tx_fall = 1'b0;
        rx_rise = 1'b0;
        tx_bit = 1'b1;
        stuff = 1'b0;
        rx_d = 1'b0;
        mode = 2'h0;
        special = 1'b0;
        next = cur;

        // pins pass three flops; a level counts once stages two and three agree
        next.txc_s = {cur.txc_s[1:0], transmit_bit_clock_i};
        next.rxc_s = {cur.rxc_s[1:0], receive_bit_clock_i};
        next.rxd_s = {cur.rxd_s[1:0], rx_data_i};
        if (cur.txc_s[1] == cur.txc_s[2]) begin
            next.txc_lvl = cur.txc_s[2];
        end
        if (cur.rxc_s[1] == cur.rxc_s[2]) begin
            next.rxc_lvl = cur.rxc_s[2];
        end
        tx_fall = cur.txc_lvl & ~next.txc_lvl;
        rx_rise = ~cur.rxc_lvl & next.rxc_lvl;
        // data travels the same three stages as the clock, so it is aligned
        rx_d = cur.rxd_s[2];

        // host side clears come first so that a same-cycle hardware set wins
        if (wr_i && addr_i == sfc_pkg::ADDR_CTRL) begin
            next.ctrl = wr_data_i;
        end
        if (wr_i && addr_i == sfc_pkg::ADDR_CMD) begin
            if (wr_data_i[sfc_pkg::CMD_TX_INT_RESET]) begin
                next.tx_int = 1'b0;
            end
            if (wr_data_i[sfc_pkg::CMD_EOM_RESET]) begin
                next.eom_latch = 1'b0;
            end
            if (wr_data_i[sfc_pkg::CMD_EXT_RESET]) begin
                next.ext_int = 1'b0;
            end
            if (wr_data_i[sfc_pkg::CMD_ERROR_RESET]) begin
                next.rx_eof = 1'b0;
                next.rx_locked = 1'b0;
                next.rx_ovr = 1'b0;
                next.rx_crc_err = 1'b0;
            end
            if (wr_data_i[sfc_pkg::CMD_ARM_FIRST]) begin
                next.rx_armed = 1'b1;
            end
            if (wr_data_i[sfc_pkg::CMD_HUNT]) begin
                next.rx_hunt = 1'b1;
                next.rx_dv = 3'h0;
                next.rx_bits = 3'h0;
            end
        end
        if (wr_i && addr_i == sfc_pkg::ADDR_TXDATA) begin
            next.tx_int = 1'b0;
        end
        if (rd_i && addr_i == sfc_pkg::ADDR_RXDATA) begin
            next.rx_full = 1'b0;
            next.rx_first = 1'b0;
        end

        // transmitter: one bit slot per falling edge of the transmit clock
        if (tx_fall) begin
            if (!cur.ctrl[sfc_pkg::CTRL_TX_EN]) begin
                next.tx_kind = sfc_pkg::SFC_TX_MARK;
                next.tx_sh = sfc_pkg::ONES_BYTE;
                next.tx_cnt = sfc_pkg::CHAR_BITS;
                next.tx_ones = 3'h0;
                tx_bit = 1'b1;
            end else begin
                // only data and crc count ones, so five ones left by the crc are stuffed before the flag
                stuff = cur.tx_ones == sfc_pkg::STUFF_ONES;
                if (stuff) begin
                    tx_bit = 1'b0;
                    next.tx_ones = 3'h0;
                end else begin
                    next.tx_cnt = cur.tx_cnt - 5'h01;
                    case (cur.tx_kind)
                        sfc_pkg::SFC_TX_DATA: begin
                            tx_bit = cur.tx_sh[0];
                            next.tx_sh = {1'b0, cur.tx_sh[7:1]};
                            next.tx_crc = tx_crc_next;
                            next.tx_ones = tx_bit ? cur.tx_ones + 3'h1 : 3'h0;
                        end
                        sfc_pkg::SFC_TX_CRC: begin
                            // complemented remainder, low bit first, also stuffed
                            tx_bit = ~cur.tx_crc[0];
                            next.tx_crc = {1'b1, cur.tx_crc[15:1]};
                            next.tx_ones = tx_bit ? cur.tx_ones + 3'h1 : 3'h0;
                        end
                        default: begin
                            tx_bit = cur.tx_sh[0];
                            next.tx_sh = {1'b0, cur.tx_sh[7:1]};
                            next.tx_ones = 3'h0;
                        end
                    endcase
                    if (cur.tx_cnt == 5'h01) begin
                        next.tx_cnt = sfc_pkg::CHAR_BITS;
                        next.tx_ones = (cur.tx_kind == sfc_pkg::SFC_TX_DATA ||
                                        cur.tx_kind == sfc_pkg::SFC_TX_CRC) ? next.tx_ones : 3'h0;
                        case (cur.tx_kind)
                            sfc_pkg::SFC_TX_MARK: begin
                                // a frame always opens with a flag, never straight from marking
                                if (cur.tx_full || cur.ctrl[sfc_pkg::CTRL_IDLE_FLAGS]) begin
                                    next.tx_kind = sfc_pkg::SFC_TX_FLAG;
                                    next.tx_sh = sfc_pkg::FLAG_BYTE;
                                end else begin
                                    next.tx_sh = sfc_pkg::ONES_BYTE;
                                end
                            end
                            sfc_pkg::SFC_TX_FLAG: begin
                                if (cur.tx_full) begin
                                    next.tx_kind = sfc_pkg::SFC_TX_DATA;
                                    next.tx_sh = cur.tx_buf;
                                    next.tx_full = 1'b0;
                                    next.tx_int = 1'b1;
                                    next.tx_crc = sfc_pkg::CRC_PRESET;
                                end else if (cur.ctrl[sfc_pkg::CTRL_IDLE_FLAGS]) begin
                                    next.tx_sh = sfc_pkg::FLAG_BYTE;
                                end else begin
                                    next.tx_kind = sfc_pkg::SFC_TX_MARK;
                                    next.tx_sh = sfc_pkg::ONES_BYTE;
                                end
                            end
                            sfc_pkg::SFC_TX_DATA: begin
                                if (cur.tx_full) begin
                                    next.tx_sh = cur.tx_buf;
                                    next.tx_full = 1'b0;
                                    next.tx_int = 1'b1;
                                end else begin
                                    next.ext_int = 1'b1;
                                    if (cur.eom_latch) begin
                                        next.tx_kind = sfc_pkg::SFC_TX_FLAG;
                                        next.tx_sh = sfc_pkg::FLAG_BYTE;
                                        next.tx_ones = 3'h0;
                                    end else if (cur.ctrl[sfc_pkg::CTRL_ABORT_UND]) begin
                                        next.eom_latch = 1'b1;
                                        next.tx_kind = sfc_pkg::SFC_TX_ABORT;
                                        next.tx_sh = sfc_pkg::ONES_BYTE;
                                        next.tx_ones = 3'h0;
                                    end else begin
                                        next.eom_latch = 1'b1;
                                        next.tx_kind = sfc_pkg::SFC_TX_CRC;
                                        next.tx_cnt = sfc_pkg::CRC_BITS;
                                    end
                                end
                            end
                            sfc_pkg::SFC_TX_CRC: begin
                                next.tx_kind = sfc_pkg::SFC_TX_FLAG;
                                next.tx_sh = sfc_pkg::FLAG_BYTE;
                                next.tx_int = 1'b1;
                            end
                            default: begin
                                next.tx_kind = sfc_pkg::SFC_TX_FLAG;
                                next.tx_sh = sfc_pkg::FLAG_BYTE;
                            end
                        endcase
                    end
                end
            end
            // fixed line delay: a byte loaded at slot k shows its first bit after slot k+6
            next.tx_pipe = {cur.tx_pipe[4:0], tx_bit};
        end

        // receiver: sampled on the rising edge of the receive clock only
        if (rx_rise) begin
            if (!cur.ctrl[sfc_pkg::CTRL_RX_EN]) begin
                next.rx_hunt = 1'b1;
                next.rx_dv = 3'h0;
                next.rx_bits = 3'h0;
                next.rx_cd_act = 1'b0;
                next.rx_flag_pend = 1'b0;
                next.rx_ones = 3'h0;
            end else begin
                next.rx_ones = rx_d ? ((cur.rx_ones == 3'h7) ? 3'h7 : cur.rx_ones + 3'h1) : 3'h0;
                if (cur.rx_cd_act) begin
                    next.rx_cd = cur.rx_cd - 3'h1;
                    if (cur.rx_cd == 3'h1) begin
                        next.rx_cd_act = 1'b0;
                        // a locked buffer drops the character rather than overwrite status
                        if (!cur.rx_locked) begin
                            next.rx_ovr = cur.rx_ovr | next.rx_full;
                            next.rx_buf = cur.rx_hold;
                            next.rx_full = 1'b1;
                            if (cur.rx_armed) begin
                                next.rx_first = 1'b1;
                                next.rx_armed = 1'b0;
                            end
                        end
                    end
                end
                if (!rx_d && cur.rx_ones == sfc_pkg::FLAG_ONES) begin
                    // outside hunt the window holds exactly the flag's leading seven bits; drop them
                    if (cur.rx_hunt) begin
                        next.rx_hunt = 1'b0;
                        next.ext_int = 1'b1;
                    end else if (cur.rx_bits != 3'h0 || cur.rx_cd_act || cur.rx_crc != sfc_pkg::CRC_PRESET) begin
                        next.rx_flag_pend = 1'b1;
                        next.rx_bad_pend = cur.rx_crc != sfc_pkg::CRC_GOOD;
                    end
                    next.rx_dv = 3'h0;
                    next.rx_bits = 3'h0;
                    next.rx_crc = sfc_pkg::CRC_PRESET;
                end else if (rx_d && cur.rx_ones >= sfc_pkg::FLAG_ONES) begin
                    if (!cur.rx_hunt) begin
                        next.rx_hunt = 1'b1;
                        next.ext_int = 1'b1;
                    end
                    next.rx_dv = 3'h0;
                    next.rx_bits = 3'h0;
                end else if (!rx_d && cur.rx_ones == sfc_pkg::STUFF_ONES) begin
                    next.rx_dv = cur.rx_dv;
                end else if (!cur.rx_hunt) begin
                    next.rx_dly = {cur.rx_dly[5:0], rx_d};
                    if (cur.rx_dv == sfc_pkg::RX_WINDOW_FULL) begin
                        next.rx_asm = {cur.rx_dly[6], cur.rx_asm[7:1]};
                        next.rx_crc = rx_crc_next;
                        next.rx_bits = cur.rx_bits + 3'h1;
                        if (cur.rx_bits == 3'h7) begin
                            next.rx_hold = {cur.rx_dly[6], cur.rx_asm[7:1]};
                            next.rx_cd = sfc_pkg::RX_HOLD_BITS;
                            next.rx_cd_act = 1'b1;
                        end
                    end else begin
                        next.rx_dv = cur.rx_dv + 3'h1;
                    end
                end
                // in dma modes the end of frame waits until the last byte is taken
                if (next.rx_flag_pend && !next.rx_cd_act &&
                    (!cur.ctrl[sfc_pkg::CTRL_MODE_LO] || !next.rx_full)) begin
                    next.rx_flag_pend = 1'b0;
                    next.rx_eof = 1'b1;
                    next.rx_locked = 1'b1;
                    next.rx_crc_err = cur.rx_bad_pend;
                end
            end
        end

        // a byte written here waits in the holding buffer for the next boundary
        if (wr_i && addr_i == sfc_pkg::ADDR_TXDATA) begin
            next.tx_buf = wr_data_i;
            next.tx_full = 1'b1;
        end

        // receive interrupt and dma request per mode; mode off means polling
        mode = next.ctrl[sfc_pkg::CTRL_MODE_LO +: 2];
        special = next.rx_eof | next.rx_ovr;
        case (mode)
            sfc_pkg::MODE_EVERY: next.rx_int = next.rx_full | special;
            sfc_pkg::MODE_FIRST: next.rx_int = next.rx_first | special;
            sfc_pkg::MODE_SPECIAL: next.rx_int = special;
            default: next.rx_int = 1'b0;
        endcase
        next.rx_int = next.rx_int & next.ctrl[sfc_pkg::CTRL_RX_EN];
        next.rx_dma = next.ctrl[sfc_pkg::CTRL_RX_EN] & mode[0] & next.rx_full & ~next.rx_locked;

        next.rd_data = 8'h00;
        if (rd_i) begin
            case (addr_i)
                sfc_pkg::ADDR_CTRL: next.rd_data = cur.ctrl;
                sfc_pkg::ADDR_RXDATA: next.rd_data = cur.rx_buf;
                sfc_pkg::ADDR_STATUS: next.rd_data = {cur.rx_locked, cur.rx_crc_err, cur.rx_eof, cur.rx_ovr,
                                                      cur.eom_latch, cur.rx_hunt, cur.rx_full, ~cur.tx_full};
                default: next.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur <= '0;
            cur.txc_s <= 3'h7;
            cur.txc_lvl <= 1'b1;
            cur.ctrl <= sfc_pkg::CTRL_RESET;
            cur.tx_kind <= sfc_pkg::SFC_TX_MARK;
            cur.tx_sh <= sfc_pkg::ONES_BYTE;
            cur.tx_cnt <= sfc_pkg::CHAR_BITS;
            cur.tx_crc <= sfc_pkg::CRC_PRESET;
            cur.tx_pipe <= 6'h3F;
            cur.eom_latch <= sfc_pkg::TX_EOM_LATCH_RESET;
            cur.rx_hunt <= 1'b1;
            cur.rx_crc <= sfc_pkg::CRC_PRESET;
            cur.rx_armed <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    assign rd_data_o = cur.rd_data;
    assign tx_data_o = cur.tx_pipe[5];
    assign tx_int_o = cur.tx_int;
    assign ext_int_o = cur.ext_int;
    assign rx_int_o = cur.rx_int;
    assign rx_dma_req_o = cur.rx_dma;
endmodule

// [sfc_frame_channel_checker.sv]
// port checker of the frame channel
`timescale 1ns/1ps
module sfc_frame_channel_checker (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic transmit_bit_clock_i,
    input wire logic tx_data_o,
    input wire logic receive_bit_clock_i,
    input wire logic rx_data_i,
    input wire logic tx_int_o,
    input wire logic ext_int_o,
    input wire logic rx_int_o,
    input wire logic rx_dma_req_o
);
    logic [1:0] mode;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            mode <= sfc_pkg::MODE_OFF;
        else if (wr_i && addr_i == sfc_pkg::ADDR_CTRL)
            mode <= wr_data_i[sfc_pkg::CTRL_MODE_LO +: 2];
    end
    sequence tx_clear;
        wr_i && (addr_i == sfc_pkg::ADDR_TXDATA || addr_i == sfc_pkg::ADDR_CMD && wr_data_i[sfc_pkg::CMD_TX_INT_RESET]);
    endsequence
    sequence ext_clear;
        wr_i && addr_i == sfc_pkg::ADDR_CMD && wr_data_i[sfc_pkg::CMD_EXT_RESET];
    endsequence
    a_read_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 8'h00) else $error("read data outside slot");
    a_unmapped_read: assert property (rd_i && addr_i > 3'h4 |=> rd_data_o == 8'h00) else $error("unmapped read");
    a_tx_int_clear: assert property (tx_clear |=> !tx_int_o) else $error("tx int not cleared");
    a_tx_int_holds: assert property (tx_int_o && !wr_i |=> tx_int_o) else $error("tx int dropped");
    a_ext_int_clear: assert property (ext_clear |=> !ext_int_o) else $error("ext int not cleared");
    a_ext_int_holds: assert property (ext_int_o && !wr_i |=> ext_int_o) else $error("ext int dropped");
    // a line change must trail a transmit clock fall through the synchroniser
    a_tx_on_fall: assert property ($changed(tx_data_o) |-> !$past(transmit_bit_clock_i, 2)) else $error("tx edge");
    a_rx_off_quiet: assert property ($past(mode) == 2'h0 && mode == 2'h0 |-> !rx_int_o) else $error("rx int");
    a_dma_mode_gate: assert property (!mode[0] |-> !rx_dma_req_o) else $error("dma in wrong mode");
endmodule
bind sfc_frame_channel sfc_frame_channel_checker chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .transmit_bit_clock_i(transmit_bit_clock_i), .tx_data_o(tx_data_o), .receive_bit_clock_i(receive_bit_clock_i),
    .rx_data_i(rx_data_i), .tx_int_o(tx_int_o), .ext_int_o(ext_int_o), .rx_int_o(rx_int_o),
    .rx_dma_req_o(rx_dma_req_o));

// [sfc_remote_station.sv]
// remote station: bit clocks, framed receive stream, capture of the line
`timescale 1ns/1ps
module sfc_remote_station (
    input wire logic line_i,
    output logic tx_clk_o,
    output logic rx_clk_o,
    output logic rx_data_o,
    output logic [15:0] hist_o
);
    int ones;
    initial begin
        tx_clk_o = 1'b1;
        rx_clk_o = 1'b0;
        rx_data_o = 1'b1;
        #7;
        forever #80 tx_clk_o = ~tx_clk_o;
    end
    always @(posedge tx_clk_o) hist_o <= {hist_o[14:0], line_i};
    // receive clock runs only inside frames and stands low between them
    task automatic put_bit(input logic b);
        rx_data_o = b;
        #40 rx_clk_o = 1'b1;
        #80 rx_clk_o = 1'b0;
        #40;
    endtask
    task automatic send(input logic [7:0] b, input bit flag);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i]);
            ones = (b[i] && !flag) ? ones + 1 : 0;
            if (ones == 5) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask
endmodule

// [sfc_frame_channel_tb_top.sv]
// self-checking bench of the frame channel
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
`define WAIT(s, n) for (int w = 0; w < (n) && (s) !== 1'b1; w++) begin @(posedge clk); #1; end
module sfc_frame_channel_tb_top;
    logic clk, rst_n, wr, rd, txd, txc, receive_bit_clock, rxd, tx_int, ext_int, rx_int, dma;
    logic [2:0] addr;
    logic [7:0] wd, rdata, v, b;
    logic [15:0] hist;
    int mismatches, check_count, cyc, falls, f0, seed;
    sfc_frame_channel dut (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wd), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdata), .transmit_bit_clock_i(txc), .tx_data_o(txd), .receive_bit_clock_i(receive_bit_clock),
        .rx_data_i(rxd), .tx_int_o(tx_int), .ext_int_o(ext_int), .rx_int_o(rx_int), .rx_dma_req_o(dma));
    sfc_remote_station st (.line_i(txd), .tx_clk_o(txc), .rx_clk_o(receive_bit_clock), .rx_data_o(rxd), .hist_o(hist));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge txc) falls++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    initial begin
        seed = 32'h022c_5a35;
        {rst_n, wr, rd, addr, wd} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(sfc_pkg::ADDR_STATUS, v);
        `CHK(v, 8'h0D)
        rd_reg(3'h5, v);
        `CHK(v, 8'h00)
        wr_reg(sfc_pkg::ADDR_CTRL, 8'h01);
        repeat (160) @(posedge clk);
        `CHK(hist, 16'hFFFF)
        wr_reg(sfc_pkg::ADDR_CTRL, 8'h03);
        // more than eight bit-times before the first byte so a flag goes first
        // and long enough for sixteen flag bits to pass the six-slot line delay
        repeat (280) @(posedge clk);
        `CHK(hist[15:8] == hist[7:0] && $countones(hist[7:0]) == 6, 1'b1)
        wr_reg(sfc_pkg::ADDR_TXDATA, 8'hFF);
        `WAIT(tx_int, 400)
        `CHK(tx_int, 1'b1)
        f0 = falls;
        wr_reg(sfc_pkg::ADDR_CMD, 8'h22);
        b = 8'($random(seed));
        wr_reg(sfc_pkg::ADDR_TXDATA, b);
        `WAIT(tx_int, 400)
        `CHK(falls - f0, 9)
        `CHK(hist[3:0], 4'h7)
        wr_reg(sfc_pkg::ADDR_CMD, 8'h01);
        `WAIT(ext_int, 600)
        `CHK(ext_int, 1'b1)
        f0 = falls;
        `WAIT(tx_int, 600)
        `CHK(falls - f0 >= 16 && falls - f0 <= 19, 1'b1)
        f0 = falls;
        wr_reg(sfc_pkg::ADDR_CTRL, 8'h01);
        // one closing flag, possibly after a trailing stuffed zero, then marking
        wait (falls == f0 + 22);
        `CHK(hist == 16'h7EFF || hist == 16'h3F7F, 1'b1)
        for (int m = 0; m < 4; m++) begin
            wr_reg(sfc_pkg::ADDR_CTRL, 8'h0B | 8'(m << 4));
            wr_reg(sfc_pkg::ADDR_CMD, 8'h3C);
            // last data bit zero keeps a stuffed bit out of the timing window
            b = 8'($random(seed)) & 8'h7F;
            st.send(sfc_pkg::FLAG_BYTE, 1'b1);
            st.send(b, 1'b0);
            st.send(8'h00, 1'b0);
            repeat (2) st.put_bit(1'b0);
            rd_reg(sfc_pkg::ADDR_STATUS, v);
            `CHK(v[2:1], 2'b00)
            `CHK(ext_int, 1'b1)
            st.put_bit(1'b0);
            rd_reg(sfc_pkg::ADDR_STATUS, v);
            `CHK(v[1], 1'b1)
            `CHK(rx_int, 1'(m == 1 || m == 2))
            `CHK(dma, 1'(m == 1 || m == 3))
            rd_reg(sfc_pkg::ADDR_RXDATA, v);
            `CHK(v, b)
        end
        finish_test();
    end
endmodule
